// >>> hdl/sla_pkg.sv
package sla_pkg;
   // ==================================================
   // register indices (byte address is four times these)
   localparam logic [7:0] IDX_FORMAT      = 8'h14;
   localparam logic [7:0] IDX_SYNC_OPT    = 8'h3A;
   localparam logic [7:0] IDX_LINK_CTRL   = 8'h5F;
   localparam logic [7:0] IDX_POLARITY    = 8'h60;
   localparam logic [7:0] IDX_DEVICE_ID   = 8'h64;
   localparam logic [7:0] IDX_BANK_ID     = 8'h65;
   localparam logic [7:0] IDX_LANE_ID     = 8'h67;
   localparam logic [7:0] IDX_SCR_LANES   = 8'h6E;
   localparam logic [7:0] IDX_OCTETS      = 8'h6F;
   localparam logic [7:0] IDX_FRAMES      = 8'h70;
   localparam logic [7:0] IDX_CONVERTERS  = 8'h71;
   localparam logic [7:0] IDX_CTRL_RES    = 8'h72;
   localparam logic [7:0] IDX_SAMPLE_BITS = 8'h73;
   localparam logic [7:0] IDX_SAMPLES     = 8'h74;
   localparam logic [7:0] IDX_DENSITY     = 8'h75;
   localparam logic [7:0] IDX_CHECKSUM    = 8'h79;
   // ==================================================
   // reset values
   localparam logic [7:0] RST_FORMAT    = 8'h01;
   localparam logic [7:0] RST_SYNC_OPT  = 8'h00;
   localparam logic [7:0] RST_LINK_CTRL = 8'h10;
   localparam logic [7:0] RST_POLARITY  = 8'h00;
   localparam logic [7:0] RST_DEVICE_ID = 8'h00;
   localparam logic [3:0] RST_BANK_ID   = 4'h0;
   localparam logic [4:0] RST_LANE_ID   = 5'h00;
   localparam logic       RST_SCR       = 1'b1;
   localparam logic [7:0] RST_FRAMES    = 8'h1F;
   localparam logic [1:0] RST_CTRL_BITS = 2'h0;
   // ==================================================
   // fixed link fields, minus-one encoded where the link says so
   localparam logic [7:0] QUICK_CFG   = 8'h11;
   localparam logic [4:0] LANES_M1    = 5'h00;
   localparam logic [7:0] OCTETS_M1   = 8'h01;
   localparam logic [7:0] CONV_M1     = 8'h00;
   localparam logic [4:0] RES_M1      = 5'h0D;
   localparam logic [4:0] SBITS_M1    = 5'h0F;
   localparam logic [4:0] SAMPLES_M1  = 5'h00;
   localparam logic [2:0] SUBCLASS    = 3'h1;
   localparam logic [2:0] VERSION     = 3'h1;
   localparam logic       HIGH_DENS   = 1'b0;
   localparam logic [4:0] CTRL_WORDS  = 5'h00;
   // ==================================================
   // field positions
   localparam int LINK_DIS_BIT  = 0;
   localparam int ILAS_LSB      = 2;
   localparam int LANE_SYNC_BIT = 4;
   localparam int POL_INV_BIT   = 1;
   localparam int SCR_BIT       = 7;
   localparam int SYSREF_EN_BIT = 0;
   localparam int SYNC_INV_BIT  = 1;
   localparam logic [1:0] FMT_OFFSET  = 2'h0;
   localparam logic [1:0] ILAS_OFF    = 2'h1;
   localparam logic [1:0] ILAS_REPEAT = 2'h2;
   // ==================================================
   // control characters and their data twins share the octet value
   localparam logic [7:0] CH_R28_0 = 8'h1C;
   localparam logic [7:0] CH_A28_3 = 8'h7C;
   localparam logic [7:0] CH_Q28_4 = 8'h9C;
   localparam logic [7:0] CH_K28_5 = 8'hBC;
   localparam logic [7:0] CH_F28_7 = 8'hFC;
   localparam logic [1:0] ILAS_LAST_MF = 2'h3;
   localparam logic [5:0] CFG_FIRST    = 6'h02;
   localparam logic [5:0] CFG_END      = 6'h10;
   localparam logic [1:0] RESP_OKAY    = 2'h0;
   localparam logic [1:0] RESP_SLVERR  = 2'h2;
   // ==================================================
   typedef struct packed {
      logic       valid;
      logic       is_k;
      logic [7:0] octet;
   } sla_octet_t;
   typedef enum logic [3:0] {
      ST_OFF  = 4'b0001,
      ST_CGS  = 4'b0010,
      ST_ILAS = 4'b0100,
      ST_DATA = 4'b1000
   } sla_state_t;
endpackage

// >>> hdl/sla_core.sv
// Notes on behaviour
// - one lane checksum, sent in ILAS and readable
// - checksum is modulo-256 sum of fields
// - lane zero checksum read-only at lane_config_checksum
// - config octets 0..10 carry fields in order
// - bit 1 of serial_output_polarity inverts serial output
// - output_format_select bits 1:0 pick format, twos default
// - sync_input_options bits 4:0 steer sysref and sync
// - clearing link_control bit 0 starts synchronization
// - quick config 0x11 read-only field values
// - scr off, sync on: repeat gives K28.7/K28.3
// - scr off, sync off: repeat gives K28.7
// - scr and sync on: D28.3/D28.7 become K
// - scr on, sync off: D28.7 becomes K28.7
// - sample sent MSB octet then LSB octet
// - setting link_control bit 0 holds link in reset
// - scramble_and_lane_count bit 7 enables scrambling, default on
// - frames per multiframe is 0x70 plus one
//
// The AXI4-Lite interface to the registers was chosen for this implementation.
module sla_core (
   // clock and reset
   input  wire logic                aclk,
   input  wire logic                aresetn,
   // axi4-lite write
   input  wire logic [11:0]         awaddr,
   input  wire logic                awvalid,
   output logic                     awready,
   input  wire logic [31:0]         wdata,
   input  wire logic [3:0]          wstrb,
   input  wire logic                wvalid,
   output logic                     wready,
   output logic [1:0]               bresp,
   output logic                     bvalid,
   input  wire logic                bready,
   // axi4-lite read
   input  wire logic [11:0]         araddr,
   input  wire logic                arvalid,
   output logic                     arready,
   output logic [31:0]              rdata,
   output logic [1:0]               rresp,
   output logic                     rvalid,
   input  wire logic                rready,
   // converter samples and pins
   input  wire logic [13:0]         sample_in,
   output logic                     sample_take,
   input  wire logic                receiver_sync_request_in,
   input  wire logic                sysref_in,
   // lane
   output sla_pkg::sla_octet_t      lane_out,
   output logic                     serial_invert
);
   // ==================================================
   // registers
   logic [7:0]  fmt_sel, sync_opt, link_ctrl, polarity, device_id, frames;
   logic [3:0]  bank_id;
   logic [4:0]  lane_id;
   logic        scr_en;
   logic [1:0]  ctrl_bits;
   logic [7:0]  fchk;
   logic [11:0] aw_addr;
   logic        aw_full, w_full;
   logic [7:0]  w_byte;
   logic        w_lane0;

   function automatic logic [7:0] addr_idx(input logic [11:0] a);
      return a[9:2];
   endfunction

   function automatic logic idx_mapped(input logic [7:0] i, input logic [1:0] lo);
      if (lo != 2'h0) begin
         return 1'b0;
      end
      case (i)
         sla_pkg::IDX_FORMAT, sla_pkg::IDX_SYNC_OPT, sla_pkg::IDX_LINK_CTRL,
         sla_pkg::IDX_POLARITY, sla_pkg::IDX_DEVICE_ID, sla_pkg::IDX_BANK_ID,
         sla_pkg::IDX_LANE_ID, sla_pkg::IDX_SCR_LANES, sla_pkg::IDX_OCTETS,
         sla_pkg::IDX_FRAMES, sla_pkg::IDX_CONVERTERS, sla_pkg::IDX_CTRL_RES,
         sla_pkg::IDX_SAMPLE_BITS, sla_pkg::IDX_SAMPLES, sla_pkg::IDX_DENSITY,
         sla_pkg::IDX_CHECKSUM: return 1'b1;
         default: return 1'b0;
      endcase
   endfunction

   // field sum before packing; wraps naturally at 8 bits
   function automatic logic [7:0] field_sum();
      logic [7:0] s;
      s = device_id + {4'h0, bank_id} + {3'h0, lane_id} + {7'h0, scr_en};
      s = s + {3'h0, sla_pkg::LANES_M1} + sla_pkg::OCTETS_M1;
      s = s + {3'h0, frames[4:0]} + sla_pkg::CONV_M1 + {6'h0, ctrl_bits};
      s = s + {3'h0, sla_pkg::RES_M1} + {5'h0, sla_pkg::SUBCLASS};
      s = s + {3'h0, sla_pkg::SBITS_M1} + {5'h0, sla_pkg::VERSION};
      s = s + {3'h0, sla_pkg::SAMPLES_M1} + {7'h0, sla_pkg::HIGH_DENS};
      s = s + {3'h0, sla_pkg::CTRL_WORDS};
      return s;
   endfunction

   // packed octets 0..10, then two don't-care, then the checksum
   function automatic logic [7:0] cfg_octet(input logic [3:0] n);
      case (n)
         4'h0: return device_id;
         4'h1: return {4'h0, bank_id};
         4'h2: return {3'h0, lane_id};
         4'h3: return {scr_en, 2'h0, sla_pkg::LANES_M1};
         4'h4: return sla_pkg::OCTETS_M1;
         4'h5: return {3'h0, frames[4:0]};
         4'h6: return sla_pkg::CONV_M1;
         4'h7: return {ctrl_bits, 1'b0, sla_pkg::RES_M1};
         4'h8: return {sla_pkg::SUBCLASS, sla_pkg::SBITS_M1};
         4'h9: return {sla_pkg::VERSION, sla_pkg::SAMPLES_M1};
         4'hA: return {3'h0, sla_pkg::CTRL_WORDS};
         4'hD: return fchk;
         default: return 8'h00;
      endcase
   endfunction

   function automatic logic [7:0] reg_value(input logic [7:0] i);
      case (i)
         sla_pkg::IDX_FORMAT:      return fmt_sel;
         sla_pkg::IDX_SYNC_OPT:    return sync_opt;
         sla_pkg::IDX_LINK_CTRL:   return link_ctrl;
         sla_pkg::IDX_POLARITY:    return polarity;
         sla_pkg::IDX_DEVICE_ID:   return device_id;
         sla_pkg::IDX_BANK_ID:     return {4'h0, bank_id};
         sla_pkg::IDX_LANE_ID:     return {3'h0, lane_id};
         sla_pkg::IDX_SCR_LANES:   return {scr_en, 2'h0, sla_pkg::LANES_M1};
         sla_pkg::IDX_OCTETS:      return sla_pkg::OCTETS_M1;
         sla_pkg::IDX_FRAMES:      return frames;
         sla_pkg::IDX_CONVERTERS:  return sla_pkg::CONV_M1;
         sla_pkg::IDX_CTRL_RES:    return {ctrl_bits, 1'b0, sla_pkg::RES_M1};
         sla_pkg::IDX_SAMPLE_BITS: return {3'h0, sla_pkg::SBITS_M1};
         sla_pkg::IDX_SAMPLES:     return {3'h0, sla_pkg::SAMPLES_M1};
         sla_pkg::IDX_DENSITY:     return {sla_pkg::HIGH_DENS, 2'h0, sla_pkg::CTRL_WORDS};
         sla_pkg::IDX_CHECKSUM:    return fchk;
         default:                  return 8'h00;
      endcase
   endfunction

   // ==================================================
   // axi4-lite write channel
   logic do_wr, wr_ok;
   assign awready = !aw_full && !bvalid;
   assign wready  = !w_full && !bvalid;
   assign do_wr   = aw_full && w_full && !bvalid;
   assign wr_ok   = idx_mapped(addr_idx(aw_addr), aw_addr[1:0]) && w_lane0;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_full <= 1'b0;
         aw_addr <= 12'h000;
      end else if (awvalid && awready) begin
         aw_full <= 1'b1;
         aw_addr <= awaddr;
      end else if (do_wr) begin
         aw_full <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_full  <= 1'b0;
         w_byte  <= 8'h00;
         w_lane0 <= 1'b0;
      end else if (wvalid && wready) begin
         w_full  <= 1'b1;
         w_byte  <= wdata[7:0];
         w_lane0 <= wstrb[0];
      end else if (do_wr) begin
         w_full <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid <= 1'b0;
         bresp  <= sla_pkg::RESP_OKAY;
      end else if (do_wr) begin
         bvalid <= 1'b1;
         bresp  <= idx_mapped(addr_idx(aw_addr), aw_addr[1:0]) ? sla_pkg::RESP_OKAY
                                                               : sla_pkg::RESP_SLVERR;
      end else if (bready) begin
         bvalid <= 1'b0;
      end
   end

   // read-only indices accept the write and keep their value
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         fmt_sel   <= sla_pkg::RST_FORMAT;
         sync_opt  <= sla_pkg::RST_SYNC_OPT;
         link_ctrl <= sla_pkg::RST_LINK_CTRL;
         polarity  <= sla_pkg::RST_POLARITY;
         device_id <= sla_pkg::RST_DEVICE_ID;
         bank_id   <= sla_pkg::RST_BANK_ID;
         lane_id   <= sla_pkg::RST_LANE_ID;
         scr_en    <= sla_pkg::RST_SCR;
         frames    <= sla_pkg::RST_FRAMES;
         ctrl_bits <= sla_pkg::RST_CTRL_BITS;
      end else if (do_wr && wr_ok) begin
         case (addr_idx(aw_addr))
            sla_pkg::IDX_FORMAT:    fmt_sel   <= w_byte;
            sla_pkg::IDX_SYNC_OPT:  sync_opt  <= {3'h0, w_byte[4:0]};
            sla_pkg::IDX_LINK_CTRL: link_ctrl <= w_byte;
            sla_pkg::IDX_POLARITY:  polarity  <= w_byte;
            sla_pkg::IDX_DEVICE_ID: device_id <= w_byte;
            sla_pkg::IDX_BANK_ID:   bank_id   <= w_byte[3:0];
            sla_pkg::IDX_LANE_ID:   lane_id   <= w_byte[4:0];
            sla_pkg::IDX_SCR_LANES: scr_en    <= w_byte[sla_pkg::SCR_BIT];
            sla_pkg::IDX_FRAMES:    frames    <= {3'h0, w_byte[4:0]};
            sla_pkg::IDX_CTRL_RES:  ctrl_bits <= w_byte[7:6];
            default: ;
         endcase
      end
   end

   // refreshed every cycle so a read sees the current fields
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         fchk <= 8'h00;
      end else begin
         fchk <= field_sum();
      end
   end

   // ==================================================
   // axi4-lite read channel
   assign arready = !rvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid <= 1'b0;
         rdata  <= 32'h0000_0000;
         rresp  <= sla_pkg::RESP_OKAY;
      end else if (arvalid && arready) begin
         rvalid <= 1'b1;
         rdata  <= {24'h00_0000, reg_value(addr_idx(araddr))};
         rresp  <= idx_mapped(addr_idx(araddr), araddr[1:0]) ? sla_pkg::RESP_OKAY
                                                             : sla_pkg::RESP_SLVERR;
      end else if (rready) begin
         rvalid <= 1'b0;
      end
   end

   // ==================================================
   // pin synchronisers: a change counts once stages 2 and 3 agree
   logic [2:0] sync_ff, sref_ff;
   logic       sync_lvl, sref_lvl, sref_old;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sync_ff  <= 3'h0;
         sref_ff  <= 3'h0;
         sync_lvl <= 1'b0;
         sref_lvl <= 1'b0;
         sref_old <= 1'b0;
      end else begin
         sync_ff  <= {sync_ff[1:0], receiver_sync_request_in};
         sref_ff  <= {sref_ff[1:0], sysref_in};
         sync_lvl <= (sync_ff[1] == sync_ff[2]) ? sync_ff[2] : sync_lvl;
         sref_lvl <= (sref_ff[1] == sref_ff[2]) ? sref_ff[2] : sref_lvl;
         sref_old <= sref_lvl;
      end
   end

   // pin low requests sync unless the option inverts it
   logic sync_req, sref_hit, link_off, lane_sync;
   logic [1:0] ilas_mode;
   assign sync_req  = !sync_lvl ^ sync_opt[sla_pkg::SYNC_INV_BIT];
   assign sref_hit  = sync_opt[sla_pkg::SYSREF_EN_BIT] && sref_lvl && !sref_old;
   assign link_off  = link_ctrl[sla_pkg::LINK_DIS_BIT];
   assign lane_sync = link_ctrl[sla_pkg::LANE_SYNC_BIT];
   assign ilas_mode = link_ctrl[sla_pkg::ILAS_LSB +: 2];

   // ==================================================
   // frame and multiframe counters
   logic       oct_sel;
   logic [4:0] frame_cnt;
   logic [1:0] mf_cnt;
   logic       eof, eomf;
   sla_pkg::sla_state_t state, next_state;

   assign eof  = oct_sel;
   assign eomf = oct_sel && (frame_cnt == frames[4:0]);

   always_ff @(posedge aclk) begin
      if (!aresetn || link_off || sref_hit) begin
         oct_sel   <= 1'b0;
         frame_cnt <= 5'h00;
      end else begin
         oct_sel   <= !oct_sel;
         frame_cnt <= eomf ? 5'h00 : frame_cnt + {4'h0, oct_sel};
      end
   end

   // ==================================================
   // link state
   always_comb begin
      next_state = state;
      case (state)
         sla_pkg::ST_OFF: begin
            if (!link_off) begin
               next_state = sla_pkg::ST_CGS;
            end
         end
         sla_pkg::ST_CGS: begin
            if (!sync_req && eomf) begin
               next_state = (ilas_mode == sla_pkg::ILAS_OFF) ? sla_pkg::ST_DATA
                                                             : sla_pkg::ST_ILAS;
            end
         end
         sla_pkg::ST_ILAS: begin
            if (sync_req) begin
               next_state = sla_pkg::ST_CGS;
            end else if (eomf && mf_cnt == sla_pkg::ILAS_LAST_MF &&
                         ilas_mode != sla_pkg::ILAS_REPEAT) begin
               next_state = sla_pkg::ST_DATA;
            end
         end
         sla_pkg::ST_DATA: begin
            if (sync_req) begin
               next_state = sla_pkg::ST_CGS;
            end
         end
         default: next_state = sla_pkg::ST_OFF;
      endcase
      if (link_off) begin
         next_state = sla_pkg::ST_OFF;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state <= sla_pkg::ST_OFF;
      end else begin
         state <= next_state;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn || state != sla_pkg::ST_ILAS) begin
         mf_cnt <= 2'h0;
      end else if (eomf) begin
         mf_cnt <= mf_cnt + 2'h1;
      end
   end

   // ==================================================
   // sample to octets
   logic [15:0] word;
   logic [7:0]  lsb_hold, data_oct, prev_last, tx_oct;
   logic        tx_k, in_data;
   logic [14:0] scr_st;
   logic [22:0] scr_res;

   assign in_data     = (state == sla_pkg::ST_DATA);
   assign sample_take = in_data && !oct_sel;
   // tail bits are fixed zeros; offset binary flips the sign bit
   assign word = {(fmt_sel[1:0] == sla_pkg::FMT_OFFSET) ? {!sample_in[13], sample_in[12:0]}
                                                         : sample_in, 2'h0};
   assign data_oct = oct_sel ? lsb_hold : word[15:8];

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         lsb_hold <= 8'h00;
      end else if (sample_take) begin
         lsb_hold <= word[7:0];
      end
   end

   // self-synchronous 1+x^14+x^15, eight bits per octet, msb first
   function automatic logic [22:0] scramble(input logic [14:0] st, input logic [7:0] d);
      logic [14:0] s;
      logic [7:0]  o;
      s = st;
      o = 8'h00;
      for (int b = 7; b >= 0; b--) begin
         o[b] = d[b] ^ s[14] ^ s[13];
         s    = {s[13:0], o[b]};
      end
      return {s, o};
   endfunction

   assign scr_res = scramble(scr_st, data_oct);

   always_ff @(posedge aclk) begin
      if (!aresetn || !in_data) begin
         scr_st <= 15'h7FFF;
      end else if (scr_en) begin
         scr_st <= scr_res[22:8];
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn || !in_data) begin
         prev_last <= 8'h00;
      end else if (eof) begin
         prev_last <= data_oct;
      end
   end

   // ilas multiframes carry the configuration only in the second one
   function automatic logic [8:0] ilas_octet(input logic [5:0] p, input logic [1:0] m,
                                             input logic last);
      if (p == 6'h00) begin
         return {1'b1, sla_pkg::CH_R28_0};
      end else if (last) begin
         return {1'b1, sla_pkg::CH_A28_3};
      end else if (m == 2'h1 && p == 6'h01) begin
         return {1'b1, sla_pkg::CH_Q28_4};
      end else if (m == 2'h1 && p >= sla_pkg::CFG_FIRST && p < sla_pkg::CFG_END) begin
         return {1'b0, cfg_octet(4'(p - sla_pkg::CFG_FIRST))};
      end
      return {1'b0, 2'h0, p};
   endfunction

   always_comb begin
      logic [8:0] il;
      il     = ilas_octet({frame_cnt, oct_sel}, mf_cnt, eomf);
      tx_oct = 8'h00;
      tx_k   = 1'b0;
      case (state)
         sla_pkg::ST_CGS: begin
            tx_oct = sla_pkg::CH_K28_5;
            tx_k   = 1'b1;
         end
         sla_pkg::ST_ILAS: begin
            tx_oct = il[7:0];
            tx_k   = il[8];
         end
         sla_pkg::ST_DATA: begin
            if (!scr_en) begin
               tx_oct = data_oct;
               if (eof && data_oct == prev_last) begin
                  tx_k   = 1'b1;
                  tx_oct = (lane_sync && eomf) ? sla_pkg::CH_A28_3
                                               : sla_pkg::CH_F28_7;
               end
            end else begin
               tx_oct = scr_res[7:0];
               if (eof && lane_sync && eomf) begin
                  tx_k = (scr_res[7:0] == sla_pkg::CH_A28_3);
               end else if (eof) begin
                  tx_k = (scr_res[7:0] == sla_pkg::CH_F28_7);
               end
            end
         end
         default: ;
      endcase
   end

   // ==================================================
   // lane outputs
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         lane_out      <= '0;
         serial_invert <= 1'b0;
      end else begin
         lane_out.valid <= (state != sla_pkg::ST_OFF);
         lane_out.is_k  <= tx_k;
         lane_out.octet <= tx_oct;
         serial_invert  <= polarity[sla_pkg::POL_INV_BIT];
      end
   end
endmodule

// >>> dv/sla_core_monitor.sv
module sla_core_monitor (
   // clock, reset and bus
   input wire logic                aclk,
   input wire logic                aresetn,
   input wire logic                awvalid,
   input wire logic                awready,
   input wire logic                wvalid,
   input wire logic                wready,
   input wire logic                bvalid,
   input wire logic                arvalid,
   input wire logic                arready,
   input wire logic                rvalid,
   input wire logic [1:0]          rresp,
   // lane
   input wire logic                sample_take,
   input wire sla_pkg::sla_octet_t lane_out
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // ==========
   // bus answers
   chk_write_answer: assert property (awvalid && awready && wvalid && wready |-> ##2 bvalid)
      else $error("write answer missing");
   chk_write_busy: assert property (bvalid |-> !awready && !wready)
      else $error("write taken while answer pending");
   chk_read_answer: assert property (arvalid && arready |=> rvalid && rresp != 2'h1)
      else $error("read answer missing");
   chk_read_busy: assert property (rvalid |-> !arready)
      else $error("read taken while answer pending");
   // ==========
   // lane framing
   chk_take_spacing: assert property (sample_take |=> !sample_take)
      else $error("frame shorter than two octets");
   chk_msb_octet: assert property (sample_take |=> lane_out.valid && !lane_out.is_k)
      else $error("first octet of frame replaced");
   chk_k_codes: assert property (lane_out.is_k |-> lane_out.valid &&
      lane_out.octet inside {8'h1C, 8'h7C, 8'h9C, 8'hBC, 8'hFC}) else $error("bad control octet");
   chk_reset_quiet: assert property ($rose(aresetn) |-> !lane_out.valid)
      else $error("lane live at reset release");
endmodule
bind sla_core sla_core_monitor u_mon (.aclk, .aresetn, .awvalid, .awready, .wvalid, .wready,
   .bvalid, .arvalid, .arready, .rvalid, .rresp, .sample_take, .lane_out);

// >>> dv/sla_rx_model.sv
module sla_rx_model (
   // lane in, sync request out
   input  wire logic                aclk,
   input  wire sla_pkg::sla_octet_t lane_out,
   output logic                     receiver_sync_request_in,
   output logic                     align_err
);
   timeunit 1ns;
   timeprecision 1ps;
   int unsigned cgs_run = 0;
   logic        pos = 1'b0;
   logic        comma;
   assign comma = lane_out.valid && lane_out.is_k && lane_out.octet == sla_pkg::CH_K28_5;
   initial receiver_sync_request_in = 1'b0;
   initial align_err = 1'b0;
   // ==========
   // a dead lane restarts the request, so re-enabling always resyncs
   always @(posedge aclk) begin
      cgs_run <= !lane_out.valid ? 0 : cgs_run + comma;
      receiver_sync_request_in <= (cgs_run >= 4);
   end
   // frame phase restarts after each comma
   always @(posedge aclk) begin
      pos <= comma ? 1'b0 : pos ^ lane_out.valid;
      if (lane_out.valid && lane_out.is_k && !pos && lane_out.octet inside {8'h7C, 8'hFC})
         align_err <= 1'b1;
   end
endmodule

// >>> dv/sla_core_bench.sv
module sla_core_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic                aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0;
   logic                arvalid = 1'b0, awready, wready, bvalid, arready, rvalid;
   logic                sample_take, serial_invert, rx_sync, align_err;
   logic [11:0]         awaddr = 12'h000, araddr = 12'h000;
   logic [31:0]         wdata = 32'h0, rdata;
   logic [13:0]         sample_in = 14'h0;
   logic [1:0]          bresp, rresp, r;
   logic [7:0]          d, did, k;
   sla_pkg::sla_octet_t lane_out;
   int                  err_total = 0, checks = 0;
   logic [7:0] ri[10] = '{8'h14, 8'h3A, 8'h5F, 8'h60, 8'h6E, 8'h6F, 8'h70, 8'h71, 8'h74, 8'h75};
   logic [7:0] rv[10] = '{8'h01, 8'h00, 8'h10, 8'h00, 8'h80, 8'h01, 8'h1F, 8'h00, 8'h00, 8'h00};
   always #12.5 aclk = ~aclk;
   // low bits fixed so every second octet repeats and must be replaced
   always @(posedge aclk) sample_in <= {8'($urandom), 6'h15};
   sla_core u_dut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb(4'hF), .wvalid,
      .wready, .bresp, .bvalid, .bready(1'b1), .araddr, .arvalid, .arready, .rdata, .rresp,
      .rvalid, .rready(1'b1), .sample_in, .sample_take, .receiver_sync_request_in(rx_sync),
      .sysref_in(1'b0), .lane_out, .serial_invert);
   sla_rx_model u_rx (.aclk, .lane_out, .receiver_sync_request_in(rx_sync), .align_err);
   // ==========
   // helpers
   task automatic cmp(input logic [15:0] g, input logic [15:0] e);
      checks++;
      if (g !== e) begin
         err_total++;
         $display("Error %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      logic ta, tw, b;
      awaddr <= {2'h0, a, 2'h0};
      wdata <= {24'h0, v};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      do begin
         @(negedge aclk);
         ta = awvalid && awready;
         tw = wvalid && wready;
         b = bvalid;
         r = bresp;
         @(posedge aclk);
         if (ta) awvalid <= 1'b0;
         if (tw) wvalid <= 1'b0;
      end while (!b);
   endtask
   task automatic rd(input logic [7:0] a);
      logic t;
      araddr <= {2'h0, a, 2'h0};
      arvalid <= 1'b1;
      do begin
         @(negedge aclk);
         t = arready;
         @(posedge aclk);
         if (t) arvalid <= 1'b0;
      end while (!t);
      do begin
         @(negedge aclk);
         t = rvalid;
         d = rdata[7:0];
         r = rresp;
         @(posedge aclk);
      end while (!t);
   endtask
   // fixed coded fields of the quick setting add 0x1F
   function automatic logic [7:0] fchk(input logic [7:0] a, input logic [7:0] kk);
      return a + 8'(a[3:0]) + 8'(a[4:0]) + 8'h01 + 8'(kk[4:0]) + 8'h1F;
   endfunction
   task automatic frames(input logic ob, input logic ls);
      logic [13:0] s;
      int          n7;
      n7 = 0;
      @(negedge aclk);
      for (int i = 0; i < 18; i++) begin
         while (sample_take !== 1'b1) @(negedge aclk);
         s = sample_in;
         @(negedge aclk);
         cmp(16'(lane_out.octet), 16'({s[13] ^ ob, s[12:6]}));
         @(negedge aclk);
         if (i > 1) cmp(16'(lane_out.is_k), 16'h0001);
         n7 += int'(i > 1 && lane_out.octet == 8'h7C);
      end
      cmp(16'(n7), ls ? 16'h0004 : 16'h0000);
      @(posedge aclk);
   endtask
   task automatic results();
      $display("checks %0d errors %0d", checks, err_total);
      if (err_total == 0 && checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // ==========
   // tests
   initial begin
      repeat (20000) @(posedge aclk);
      err_total++;
      results();
   end
   initial begin
      void'($urandom(32'h013E));
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      for (int i = 0; i < 10; i++) begin
         rd(ri[i]);
         cmp(16'(d), 16'(rv[i]));
      end
      rd(8'h79);
      cmp(16'(d), 16'(fchk(8'h00, 8'h1F)));
      repeat (3) begin
         did = 8'($urandom);
         k = 8'($urandom);
         wr(8'h64, did);
         wr(8'h65, {4'h0, did[3:0]});
         wr(8'h67, {3'h0, did[4:0]});
         wr(8'h70, k);
         wr(8'h79, ~did);
         rd(8'h79);
         cmp(16'(d), 16'(fchk(did, k)));
      end
      wr(8'h00, 8'h5A);
      cmp(16'(r), 16'(sla_pkg::RESP_SLVERR));
      rd(8'h00);
      cmp({6'h00, r, d}, {6'h00, sla_pkg::RESP_SLVERR, 8'h00});
      wr(8'h3A, 8'hFD);
      rd(8'h3A);
      cmp(16'(d), 16'h001D);
      wr(8'h60, 8'h02);
      @(negedge aclk);
      cmp(16'(serial_invert), 16'h0001);
      @(posedge aclk);
      wr(8'h5F, 8'h15);
      repeat (2) @(negedge aclk);
      cmp(16'(lane_out.valid), 16'h0000);
      @(posedge aclk);
      wr(8'h6E, 8'h00);
      wr(8'h70, 8'h03);
      wr(8'h5F, 8'h14);
      frames(1'b0, 1'b1);
      wr(8'h5F, 8'h05);
      wr(8'h14, 8'h00);
      wr(8'h5F, 8'h04);
      frames(1'b1, 1'b0);
      cmp(16'(align_err), 16'h0000);
      results();
   end
endmodule
